/* ebg_port.sv */
// External memory bus port: request/grant handover and read cycle.
// Assumes one clk; processor cycle is four clk phases; pins resolved outside.
// Notes on behaviour
// - Request sampled once per processor cycle; late request taken next cycle.
// - Grant goes low the processor cycle after release; release waits for any read in progress to end.
// - Request is synchronised inside, no external synchroniser needed.
// - Selects and strobes released to high impedance before grant goes low.
// - Selects and strobes driven again no earlier than grant going high.
// - Read strobe lengthened by programmed wait states times processor cycle.
`include "ebg_params.svh"
module ebg_port #(
	parameter int WAIT_W = `EBG_WAIT_W,
	parameter int ADDR_W = `EBG_ADDR_W,
	parameter int DATA_W = `EBG_DATA_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_request_n,
	output logic bus_grant_n,
	output logic processor_clock_out,
	output logic data_mem_select_n,
	output logic prog_mem_select_n,
	output logic boot_mem_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic strobes_oe_n,
	output logic [ADDR_W-1:0] mem_addr,
	input wire logic [DATA_W-1:0] mem_data_in,
	input wire logic [WAIT_W-1:0] wait_states,
	input wire logic rd_req,
	input wire logic [1:0] rd_space,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic rd_ready,
	output logic rd_done,
	output logic [DATA_W-1:0] rd_data
);
	logic [`EBG_PHASE_W-1:0] phase_q, phase_d;
	logic cyc_start;
	logic recognised;
	ebg_pkg::ebg_state_e state_q, state_d;
	logic [WAIT_W-1:0] wcnt_q, wcnt_d;
	logic [1:0] sub_q, sub_d;
	logic [2:0] sel_q, sel_d;
	logic rd_q, rd_d;
	logic oe_n_q, oe_n_d;
	logic bg_n_q, bg_n_d;
	logic done_q, done_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] data_q, data_d;
	logic ev_release;
	logic ev_take;
	logic ev_strobe;
	logic ev_end;
	logic ev_grant;
	logic ev_ungrant;
	logic ev_reclaim;

	ebg_req_sync u_sync (
		.clk(clk),
		.reset(reset),
		.async_in_n(bus_request_n),
		.sample_en(phase_q == `EBG_PHASE_LOW),
		.recognised(recognised)
	);

	assign cyc_start = (phase_q == `EBG_PHASE_RISE);

	// Processor cycle phase counter
	always_comb begin
		phase_d = phase_q + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			phase_q <= `EBG_PHASE_RISE;
		end else begin
			phase_q <= phase_d;
		end
	end

	// Bus ownership and read sequencing
	always_comb begin
		state_d = state_q;
		wcnt_d = wcnt_q;
		sub_d = sub_q;
		ev_release = 1'b0;
		ev_take = 1'b0;
		ev_strobe = 1'b0;
		ev_end = 1'b0;
		ev_grant = 1'b0;
		ev_ungrant = 1'b0;
		ev_reclaim = 1'b0;
		unique case (state_q)
			ebg_pkg::EBG_IDLE: begin
				if (cyc_start && recognised) begin
					ev_release = 1'b1;
					state_d = ebg_pkg::EBG_RELEASE;
				end else if (cyc_start && rd_req) begin
					ev_take = 1'b1;
					wcnt_d = wait_states;
					sub_d = 2'h0;
					state_d = ebg_pkg::EBG_READ;
				end
			end
			ebg_pkg::EBG_READ: begin
				if (phase_q == 2'h1 && sub_q == 2'h0) begin
					ev_strobe = 1'b1;
				end
				if (cyc_start) begin
					sub_d = 2'h1;
				end
				if (phase_q == 2'h3 && sub_q != 2'h0) begin
					if (wcnt_q != '0) begin
						wcnt_d = wcnt_q - 1'b1;
					end else begin
						ev_end = 1'b1;
						state_d = ebg_pkg::EBG_IDLE;
					end
				end
			end
			ebg_pkg::EBG_RELEASE: begin
				if (cyc_start) begin
					ev_grant = 1'b1;
					state_d = ebg_pkg::EBG_GRANTED;
				end
			end
			ebg_pkg::EBG_GRANTED: begin
				if (cyc_start && !recognised) begin
					ev_ungrant = 1'b1;
					state_d = ebg_pkg::EBG_RECLAIM;
				end
			end
			ebg_pkg::EBG_RECLAIM: begin
				ev_reclaim = 1'b1;
				state_d = ebg_pkg::EBG_IDLE;
			end
			default: begin
				state_d = ebg_pkg::EBG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ebg_pkg::EBG_IDLE;
			wcnt_q <= `EBG_WAIT_RESET;
			sub_q <= 2'h0;
		end else begin
			state_q <= state_d;
			wcnt_q <= wcnt_d;
			sub_q <= sub_d;
		end
	end

	// Pin and result registers
	always_comb begin
		sel_d = sel_q;
		rd_d = rd_q;
		oe_n_d = oe_n_q;
		bg_n_d = bg_n_q;
		done_d = 1'b0;
		addr_d = addr_q;
		data_d = data_q;
		if (ev_release) begin
			oe_n_d = 1'b1;
			sel_d = 3'h7;
			rd_d = 1'b1;
		end
		if (ev_take) begin
			addr_d = rd_addr;
			sel_d = ~(3'h1 << rd_space);
		end
		if (ev_strobe) begin
			rd_d = 1'b0;
		end
		if (ev_end) begin
			data_d = mem_data_in;
			rd_d = 1'b1;
			sel_d = 3'h7;
			done_d = 1'b1;
		end
		if (ev_grant) begin
			bg_n_d = 1'b0;
		end
		if (ev_ungrant) begin
			bg_n_d = 1'b1;
		end
		if (ev_reclaim) begin
			oe_n_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sel_q <= 3'h7;
			rd_q <= 1'b1;
			oe_n_q <= 1'b0;
			bg_n_q <= 1'b1;
			done_q <= 1'b0;
			addr_q <= '0;
			data_q <= '0;
		end else begin
			sel_q <= sel_d;
			rd_q <= rd_d;
			oe_n_q <= oe_n_d;
			bg_n_q <= bg_n_d;
			done_q <= done_d;
			addr_q <= addr_d;
			data_q <= data_d;
		end
	end

	// Output clock high in phases 0 and 1
	assign processor_clock_out = ~phase_q[1];
	assign bus_grant_n = bg_n_q;
	assign data_mem_select_n = sel_q[0];
	assign prog_mem_select_n = sel_q[1];
	assign boot_mem_select_n = sel_q[2];
	assign read_strobe_n = rd_q;
	assign write_strobe_n = 1'b1;
	assign strobes_oe_n = oe_n_q;
	assign mem_addr = addr_q;
	assign rd_ready = (state_q == ebg_pkg::EBG_IDLE) && cyc_start && !recognised;
	assign rd_done = done_q;
	assign rd_data = data_q;
endmodule : ebg_port

/* ebg_params.svh */
// Constants for the external bus grant and read port.
// Assumes inclusion by bare name from design files; no side effects.
`ifndef EBG_PARAMS_SVH
`define EBG_PARAMS_SVH
`define EBG_WAIT_W 3
`define EBG_ADDR_W 14
`define EBG_DATA_W 24
`define EBG_PHASE_W 2
`define EBG_PHASE_RISE 2'h0
`define EBG_PHASE_LOW 2'h2
`define EBG_WAIT_RESET 3'h0
`endif

/* ebg_pkg.sv */
// Types for the external bus grant and read port.
// Assumes ebg_params.svh is on the include path.
`include "ebg_params.svh"
package ebg_pkg;
	typedef enum logic [4:0] {
		EBG_IDLE = 5'b0_0001,
		EBG_READ = 5'b0_0010,
		EBG_RELEASE = 5'b0_0100,
		EBG_GRANTED = 5'b0_1000,
		EBG_RECLAIM = 5'b1_0000
	} ebg_state_e;
	typedef logic [`EBG_WAIT_W-1:0] ebg_wait_t;
endpackage : ebg_pkg

/* ebg_req_sync.sv */
// Two-stage synchroniser with recognition level, held between sample_en strobes, for the bus request.
// Assumes the request may change at any time relative to clk.
module ebg_req_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic async_in_n,
	input wire logic sample_en,
	output logic recognised
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic rec_q, rec_d;
	always_comb begin
		meta_d = ~async_in_n;
		sync_d = meta_q;
		rec_d = sample_en ? sync_q : rec_q;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			rec_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			rec_q <= rec_d;
		end
	end
	assign recognised = rec_q;
endmodule : ebg_req_sync

/* ebg_asserts.sv */
// Checker: grant handover and read strobe timing.
// Assumes binding to ebg_port.
module ebg_asserts #(parameter int WAIT_W = 3) (
	input wire logic clk,
	input wire logic reset,
	input wire logic processor_clock_out,
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic read_strobe_n,
	input wire logic strobes_oe_n,
	input wire logic [WAIT_W-1:0] wait_states,
	input wire logic rd_done
);
	logic [7:0] len_q;
	logic [7:0] len_d;
	always_comb len_d = read_strobe_n ? 8'h00 : len_q + 8'h01;
	always_ff @(posedge clk) len_q <= reset ? 8'h00 : len_d;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rec; $fell(bus_request_n) |-> ##[1:48] (strobes_oe_n || bus_request_n); endproperty
	a_rec: assert property (p_rec) else $error("request not seen");
	property p_gnt; $rose(strobes_oe_n) |-> bus_grant_n[*4] ##1 !bus_grant_n; endproperty
	a_gnt: assert property (p_gnt) else $error("grant timing");
	property p_rel; $fell(bus_grant_n) |-> strobes_oe_n && $past(strobes_oe_n, 4); endproperty
	a_rel: assert property (p_rel) else $error("grant before release");
	property p_back; $fell(strobes_oe_n) |-> bus_grant_n && $past(bus_grant_n); endproperty
	a_back: assert property (p_back) else $error("drive before grant high");
	property p_len;
		$rose(read_strobe_n) |-> len_q >= 4 * wait_states + 4 && len_q <= 4 * wait_states + 7;
	endproperty
	a_len: assert property (p_len) else $error("strobe length");
	property p_done; $rose(read_strobe_n) |-> rd_done; endproperty
	a_done: assert property (p_done) else $error("done not with strobe end");
	property p_processor_clock_out;
		$rose(processor_clock_out) |-> processor_clock_out ##1 processor_clock_out
			##1 !processor_clock_out ##1 !processor_clock_out ##1 processor_clock_out;
	endproperty
	a_processor_clock_out: assert property (p_processor_clock_out) else $error("clock out phases");
	property p_gphase;
		$changed(bus_grant_n) |-> processor_clock_out && $past(processor_clock_out);
	endproperty
	a_gphase: assert property (p_gphase) else $error("grant off cycle boundary");
	c_grant: cover property ($fell(bus_grant_n));
	c_read: cover property ($rose(rd_done));
	c_wmax: cover property (rd_done && &wait_states);
endmodule : ebg_asserts

/* ebg_mem_model.sv */
// Memory model: answers reads with address and select pattern.
// Assumes wait states cover its access time.
module ebg_mem_model (
	input wire logic [13:0] addr,
	input wire logic rd_n,
	input wire logic [2:0] sel_n,
	output logic [23:0] data
);
	logic [23:0] v;
	assign v = {addr, 7'h00, sel_n};
	assign data = (rd_n || &sel_n) ? ~v : v;
endmodule : ebg_mem_model

/* tb.sv */
// Bench: random reads and grant handovers.
// Assumes ebg_port, ebg_mem_model and ebg_asserts compiled.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset = 1, req_n = 1, rd_req = 0, g_n, oe_n, rs_n, rdy, done, d_n, p_n, b_n;
	logic [1:0] sp = 2'h0;
	logic [2:0] ws = 3'h0;
	logic [13:0] ad = 14'h0000, ma;
	logic [23:0] din, q;
	logic ck_o, wr_n;
	int num_errors = 0, total_checks = 0, seed = 8;
	ebg_port ebg_port_i (.clk(clk), .reset(reset), .bus_request_n(req_n), .bus_grant_n(g_n),
		.processor_clock_out(ck_o), .data_mem_select_n(d_n), .prog_mem_select_n(p_n),
		.boot_mem_select_n(b_n), .read_strobe_n(rs_n), .write_strobe_n(wr_n),
		.strobes_oe_n(oe_n), .mem_addr(ma), .mem_data_in(din), .wait_states(ws),
		.rd_req(rd_req), .rd_space(sp), .rd_addr(ad), .rd_ready(rdy), .rd_done(done),
		.rd_data(q));
	// Released pins read as pulled high
	ebg_mem_model ebg_mem_model_i (.addr(ma), .rd_n(rs_n | oe_n),
		.sel_n(oe_n ? 3'h7 : {b_n, p_n, d_n}), .data(din));
	function automatic logic [23:0] exp_data(logic [13:0] a, logic [1:0] s);
		return {a, 7'h00, ~(3'h1 << s)};
	endfunction : exp_data
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_pin(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk_pin
	task automatic chk_lat(input string nm, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, got);
		end
	endtask : chk_lat
	task automatic rd(input logic [1:0] s, input logic [13:0] a, input logic [2:0] w);
		int n;
		n = 0;
		rd_req <= 1'b1;
		sp <= s;
		ad <= a;
		ws <= w;
		do @(posedge clk); while (!(rdy && rd_req) && ++n < 100);
		if (n >= 100) num_errors++;
		rd_req <= 1'b0;
		do @(posedge clk); while (done !== 1'b1 && ++n < 200);
		if (done !== 1'b1) num_errors++;
		chk("rd_data", exp_data(a, s), q);
		chk_pin("write_strobe_n", 1'b1, wr_n);
	endtask : rd
	task automatic grab(input int hold, input bit tight);
		int n;
		n = 0;
		req_n <= 1'b0;
		do @(posedge clk); while (g_n !== 1'b0 && ++n < 100);
		if (g_n !== 1'b0) num_errors++;
		if (tight) chk_lat("grant_latency", 9, 12, n);
		chk_pin("oe_grant", 1'b1, oe_n);
		repeat (hold) @(posedge clk);
		chk_pin("grant_held", 1'b0, g_n);
		req_n <= 1'b1;
		do @(posedge clk); while (g_n !== 1'b1 && ++n < 200);
		if (g_n !== 1'b1) num_errors++;
		repeat (2) @(posedge clk);
		chk_pin("oe_back", 1'b0, oe_n);
	endtask : grab
	task automatic close_out;
		if (num_errors == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#50000;
		num_errors++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(2'h0, 14'h0000, 3'h0);
		rd(2'h2, 14'h3fff, 3'h7);
		repeat (20) rd(2'($unsigned($random(seed)) % 3), 14'($random(seed)), 3'($random(seed)));
		grab(0, 1'b1);
		fork
			rd(2'h1, 14'h1555, 3'h3);
			begin
				repeat (3) @(posedge clk);
				grab(5, 1'b0);
			end
		join
		repeat (6) begin
			repeat ($unsigned($random(seed)) % 4) @(posedge clk);
			grab($unsigned($random(seed)) % 8, 1'b1);
		end
		close_out();
	end
endmodule : tb
bind ebg_port ebg_asserts #(.WAIT_W(WAIT_W)) ebg_asserts_i (.clk(clk), .reset(reset),
	.processor_clock_out(processor_clock_out),
	.bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .read_strobe_n(read_strobe_n),
	.strobes_oe_n(strobes_oe_n), .wait_states(wait_states), .rd_done(rd_done));
